/* shared/ccd_pkg.sv */
// Constants and types shared by the card clock divider
package ccd_pkg;

  // ****************************************
  // Command byte layout
  // ****************************************
  localparam int unsigned CMD_W         = 8;
  localparam int unsigned CMD_SLOPE_BIT = 1;   // 1 = fast edge slope
  localparam int unsigned CMD_RATIO_LSB = 2;   // Bits 3:2 select the ratio
  localparam int unsigned CMD_RESET_BIT = 4;   // Drives the card reset pin
  localparam logic [3:0]  BIT_CNT_FULL  = 4'h8;

  // ****************************************
  // Status layout and reset values
  // ****************************************
  localparam int unsigned ST_CARD_OV = 0;
  localparam int unsigned ST_CARD_UV = 1;
  localparam int unsigned ST_BAT_OV  = 2;
  localparam int unsigned ST_BAT_UV  = 3;
  localparam logic [7:0]  CMD_RST    = 8'h00;
  localparam logic [3:0]  STATUS_RST = 4'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam logic [2:0] SWITCH_MAX_RISES = 3'h4;  // Ratio change latency in input pulses

  // ****************************************
  // Clock modes
  // ****************************************
  typedef enum logic [1:0] {
    CCD_LOW,
    CCD_DIV1,
    CCD_DIV2,
    CCD_DIV4
  } ccd_mode_t;

endpackage : ccd_pkg

/* hdl/ccd_card_clock_divider.sv */
// Card clock divider with serial command latch and supply fault flags
// Operation
// - Card clock is input clock divided by one, two or four per command
// - One ratio code holds the card clock statically low
// - Divider output toggles only from its last stage, giving 50% duty
// - A new ratio takes effect within four input clock pulses
// - Ratio one passes the synchronised input clock to the card through one register
// - Slope select picks slow or fast edge, changeable any time
// - Every latched command sets card reset to command bit four
// - Clock programming comes from command bits two and three
// - Card supply faults set status and pull interrupt low
// - Battery faults are recorded in the status register
// - Configuration applies only at chip select rise after eight bits
module ccd_card_clock_divider
  import ccd_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  // Serial command port pins
  input  wire logic       cs_b_i,
  input  wire logic       spi_clk_i,
  input  wire logic       mosi_i,
  // Input clock pin
  input  wire logic       clk_in_i,
  // Supply comparators
  input  wire logic       card_supply_ov_i,
  input  wire logic       card_supply_uv_i,
  input  wire logic       battery_ov_i,
  input  wire logic       battery_uv_i,
  // Card side
  output logic            card_clock_out_o,
  output logic            card_reset_out_o,
  output logic            fast_edge_slope_o,
  // Host side status
  output logic [3:0]      status_o,
  output logic            int_b_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int unsigned NSYNC = 8;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_ff;
  logic [NSYNC-1:0] sync_ff;
  logic [NSYNC-1:0] nxt_meta;
  logic [NSYNC-1:0] nxt_sync;
  logic             cs_d_ff;
  logic             sclk_d_ff;
  logic             cin_d_ff;

  assign pin_raw = {battery_uv_i, battery_ov_i, card_supply_uv_i, card_supply_ov_i,
                    clk_in_i, mosi_i, spi_clk_i, cs_b_i};

  // Two stages per pin; only the second stage feeds logic
  always_comb begin
    nxt_meta = pin_raw;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_ff   <= 8'h01;  // Same idle levels as the second stage, so no false edge follows reset
      sync_ff   <= 8'h01;
      cs_d_ff   <= 1'b1;
      sclk_d_ff <= 1'b0;
      cin_d_ff  <= 1'b0;
    end else begin
      meta_ff   <= nxt_meta;
      sync_ff   <= nxt_sync;
      cs_d_ff   <= sync_ff[0];
      sclk_d_ff <= sync_ff[1];
      cin_d_ff  <= sync_ff[3];
    end
  end

  logic cs_b_s;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic cin_s;
  logic cin_rise;
  assign cs_b_s    = sync_ff[0];
  assign cs_fall   = !cs_b_s && cs_d_ff;
  assign cs_rise   = cs_b_s && !cs_d_ff;
  assign sclk_rise = sync_ff[1] && !sclk_d_ff && !cs_b_s;
  assign cin_s     = sync_ff[3];
  assign cin_rise  = cin_s && !cin_d_ff;

  // ****************************************
  // Command shift register and latch
  // ****************************************
  function automatic ccd_mode_t ratio_decode(input logic [1:0] code);
    case (code)
      2'h0:    ratio_decode = CCD_LOW;
      2'h1:    ratio_decode = CCD_DIV1;
      2'h2:    ratio_decode = CCD_DIV2;
      default: ratio_decode = CCD_DIV4;
    endcase
  endfunction

  logic [CMD_W-1:0] shift_ff;
  logic [CMD_W-1:0] nxt_shift;
  logic [3:0]       bits_ff;
  logic [3:0]       nxt_bits;
  logic [CMD_W-1:0] cmd_ff;
  logic [CMD_W-1:0] nxt_cmd;
  logic             latch;
  ccd_mode_t        pend_mode;

  assign latch = cs_rise && (bits_ff == BIT_CNT_FULL);

  // Shift MSB first, clear at frame start, commit at frame end
  always_comb begin
    nxt_shift = shift_ff;
    nxt_bits  = bits_ff;
    nxt_cmd   = cmd_ff;
    if (cs_fall) begin
      nxt_shift = '0;
      nxt_bits  = '0;
    end else if (sclk_rise) begin
      nxt_shift = {shift_ff[CMD_W-2:0], sync_ff[2]};
      if (bits_ff != BIT_CNT_FULL) begin
        nxt_bits = bits_ff + 4'h1;
      end
    end
    if (latch) begin
      nxt_cmd = shift_ff;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_ff <= '0;
      bits_ff  <= '0;
      cmd_ff   <= CMD_RST;
    end else begin
      shift_ff <= nxt_shift;
      bits_ff  <= nxt_bits;
      cmd_ff   <= nxt_cmd;
    end
  end

  assign pend_mode         = ratio_decode(cmd_ff[CMD_RATIO_LSB +: 2]);
  assign card_reset_out_o  = cmd_ff[CMD_RESET_BIT];
  assign fast_edge_slope_o = cmd_ff[CMD_SLOPE_BIT];

  // ****************************************
  // Divider
  // ****************************************
  ccd_mode_t mode_ff;
  ccd_mode_t nxt_mode;
  logic      clk_ff;
  logic      nxt_clk;
  logic      half_ff;
  logic      nxt_half;
  logic      low_end;

  // A low phase ends at this input rise; safe point to change ratio
  always_comb begin
    case (mode_ff)
      CCD_LOW:  low_end = 1'b1;
      CCD_DIV1: low_end = 1'b1;
      CCD_DIV2: low_end = !clk_ff;
      CCD_DIV4: low_end = !clk_ff && half_ff;
      default:  low_end = 1'b1;
    endcase
  end

  // In divide by two and four the output toggles only on input rises, so high and low phases match
  always_comb begin
    nxt_mode = mode_ff;
    nxt_clk  = clk_ff;
    nxt_half = half_ff;
    if (cin_rise && low_end && (pend_mode != mode_ff)) begin
      nxt_mode = pend_mode;
      nxt_half = 1'b0;
      nxt_clk  = (pend_mode != CCD_LOW);
    end else begin
      case (mode_ff)
        CCD_LOW:  nxt_clk = 1'b0;
        CCD_DIV1: nxt_clk = cin_s;
        CCD_DIV2: begin
          if (cin_rise) begin
            nxt_clk = !clk_ff;
          end
        end
        CCD_DIV4: begin
          if (cin_rise) begin
            nxt_half = !half_ff;
            if (half_ff) begin
              nxt_clk = !clk_ff;
            end
          end
        end
        default:  nxt_clk = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_ff <= CCD_LOW;
      clk_ff  <= 1'b0;
      half_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      clk_ff  <= nxt_clk;
      half_ff <= nxt_half;
    end
  end

  assign card_clock_out_o = clk_ff;

  // ****************************************
  // Supply fault status
  // ****************************************
  logic [3:0] status_ff;
  logic [3:0] nxt_status;
  logic [3:0] fault_s;

  assign fault_s = sync_ff[7:4];

  // Sticky flags; a latched command clears them but a live fault wins
  always_comb begin
    nxt_status = status_ff;
    if (latch) begin
      nxt_status = STATUS_RST;
    end
    nxt_status = nxt_status | fault_s;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign status_o = status_ff;
  assign int_b_o  = !(status_ff[ST_CARD_OV] || status_ff[ST_CARD_UV]);

  // ****************************************
  // Checks
  // ****************************************
  logic [2:0] wait_ff;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_ff <= '0;
    end else if (pend_mode == mode_ff) begin
      wait_ff <= '0;
    end else if (cin_rise && wait_ff != 3'h7) begin
      wait_ff <= wait_ff + 3'h1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  low_hold_a: assert property (mode_ff == CCD_LOW && $past(mode_ff) == CCD_LOW |-> !clk_ff)
    else $error("card clock not low in stop mode");
  div2_toggle_a: assert property (mode_ff == CCD_DIV2 && pend_mode == CCD_DIV2 && cin_rise |=> $changed(clk_ff))
    else $error("divide by two missed a toggle");
  div4_skip_a: assert property (mode_ff == CCD_DIV4 && pend_mode == CCD_DIV4 && cin_rise && !half_ff |=> $stable(clk_ff))
    else $error("divide by four toggled early");
  edge_src_a: assert property ((mode_ff inside {CCD_DIV2, CCD_DIV4}) && $changed(clk_ff) |-> $past(cin_rise))
    else $error("divided clock changed without input rise");
  switch_lat_a: assert property (wait_ff <= SWITCH_MAX_RISES)
    else $error("ratio change took too many input pulses");
  follow_in_a: assert property (mode_ff == CCD_DIV1 && pend_mode == CCD_DIV1 |=> clk_ff == $past(cin_s))
    else $error("ratio one does not follow input");
  cmd_apply_a: assert property (latch |=> card_reset_out_o == $past(shift_ff[CMD_RESET_BIT])
                                && fast_edge_slope_o == $past(shift_ff[CMD_SLOPE_BIT]))
    else $error("command fields not applied at latch");
  cmd_hold_a: assert property (!latch |=> $stable(cmd_ff))
    else $error("command changed outside latch");
  ratio_field_a: assert property (latch |=> pend_mode == ratio_decode($past(shift_ff[CMD_RATIO_LSB +: 2])))
    else $error("ratio not taken from bits three and two");
  safe_switch_a: assert property ($changed(mode_ff) |-> $past(cin_rise && low_end))
    else $error("ratio changed mid phase");
  card_int_a: assert property (fault_s[ST_CARD_OV] || fault_s[ST_CARD_UV] |=> !int_b_o
                               ##1 (!int_b_o || $past(latch)))
    else $error("card supply fault did not raise interrupt");
  bat_flag_a: assert property (fault_s[ST_BAT_OV] |=> status_o[ST_BAT_OV])
    else $error("battery fault not recorded");

  div4_run_c: cover property (mode_ff == CCD_DIV4 ##1 $rose(clk_ff) ##[1:40] $fell(clk_ff));
  stop_c:     cover property (mode_ff == CCD_DIV2 ##[1:200] mode_ff == CCD_LOW);
  fault_c:    cover property ($fell(int_b_o));

endmodule // ccd_card_clock_divider

/* bench/ccd_card_model.sv */
// Card contact model that measures the card clock phase lengths
module ccd_card_model (
  // Clock
  input  wire logic       clk_i,
  // Card contact
  input  wire logic       card_clock_i,
  // Measurements
  output logic [7:0]      hi_len_o,
  output logic [7:0]      lo_len_o,
  output logic [7:0]      run_o,
  output logic            too_fast_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       prev     = 1'b0;
  logic [7:0] hi_len   = 8'h00;
  logic [7:0] lo_len   = 8'h00;
  logic [7:0] run      = 8'h00;
  logic       too_fast = 1'b0;
  assign hi_len_o   = hi_len;
  assign lo_len_o   = lo_len;
  assign run_o      = run;
  assign too_fast_o = too_fast;
  // Length of each finished phase, in system clock samples
  // An undriven level before the first reset edge does not count as a phase end
  always @(posedge clk_i) begin
    prev <= card_clock_i;
    if (card_clock_i != prev) begin
      if (prev) hi_len <= run;
      else lo_len <= run;
      run <= 8'h01;
      // The card takes no more than 20 MHz, so a phase under 3 samples is too fast
      if (run < 8'h03 && run != 8'h00) too_fast <= 1'b1;
    end else if (run != 8'hff) begin
      run <= run + 8'h01;
    end
  end
endmodule // ccd_card_model

/* bench/ccd_card_clock_divider_test.sv */
// Self-checking testbench of the card clock divider
module ccd_card_clock_divider_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ccd_pkg::*;
  logic       sys_clk_i = 1'b0, rst_b_i = 1'b0, cs_b_i = 1'b1, spi_clk_i = 1'b0, mosi_i = 1'b0;
  logic       clk_in_i = 1'b0, card_supply_ov_i = 1'b0, card_supply_uv_i = 1'b0;
  logic       battery_ov_i = 1'b0, battery_uv_i = 1'b0;
  logic       card_clock_out_o, card_reset_out_o, fast_edge_slope_o, int_b_o, too_fast;
  logic [3:0] status_o;
  logic [7:0] hi_len, lo_len, run, cmd;
  int         err_total = 0, samples_checked = 0, cycles = 0;
  ccd_card_clock_divider i_ccd_card_clock_divider (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .cs_b_i(cs_b_i), .spi_clk_i(spi_clk_i), .mosi_i(mosi_i), .clk_in_i(clk_in_i),
    .card_supply_ov_i(card_supply_ov_i), .card_supply_uv_i(card_supply_uv_i),
    .battery_ov_i(battery_ov_i), .battery_uv_i(battery_uv_i), .card_clock_out_o(card_clock_out_o),
    .card_reset_out_o(card_reset_out_o), .fast_edge_slope_o(fast_edge_slope_o),
    .status_o(status_o), .int_b_o(int_b_o));
  ccd_card_model i_ccd_card_model (.clk_i(sys_clk_i), .card_clock_i(card_clock_out_o),
    .hi_len_o(hi_len), .lo_len_o(lo_len), .run_o(run), .too_fast_o(too_fast));
  // ****************************************
  // Clocks and timeout
  // ****************************************
  initial forever #5 sys_clk_i = ~sys_clk_i;
  initial forever begin
    repeat (4) @(posedge sys_clk_i);
    clk_in_i <= ~clk_in_i;  // Input clock of eight system cycles
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end
  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] half(input logic [1:0] code);
    return (code == 2'h1) ? 8'h04 : (code == 2'h2) ? 8'h08 : (code == 2'h3) ? 8'h10 : 8'h00;
  endfunction
  // Serial frame of n bits, MSB first
  task automatic send(input logic [7:0] b, input int n);
    cs_b_i <= 1'b0;
    cyc(4);
    for (int i = 0; i < n; i++) begin
      mosi_i <= b[7 - i];
      cyc(3);
      spi_clk_i <= 1'b1;
      cyc(3);
      spi_clk_i <= 1'b0;
    end
    cyc(3);
    cs_b_i <= 1'b1;
    cyc(8);
  endtask
  // Valid command, then pins and card clock checked
  task automatic command(input logic [7:0] b);
    send(b, 8);
    chk({7'h00, card_reset_out_o}, {7'h00, b[CMD_RESET_BIT]});
    chk({7'h00, fast_edge_slope_o}, {7'h00, b[CMD_SLOPE_BIT]});
    // Host waits more than four input pulses before looking at the card clock
    cyc(80);
    if (half(b[3:2]) == 8'h00) begin
      chk({7'h00, card_clock_out_o}, 8'h00);
      chk({7'h00, run > 8'h40}, 8'h01);
    end else begin
      chk(hi_len, half(b[3:2]));
      chk(lo_len, half(b[3:2]));
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(61721));
    cyc(5);
    rst_b_i <= 1'b1;
    cyc(2);
    for (int m = 0; m < 8; m++) command({3'h0, m[0], m[2:1], m[0], 1'b0});
    $display("test ratio_table done");
    for (int m = 0; m < 8; m++) command(8'($urandom));
    $display("test random_commands done");
    cmd = 8'($urandom);
    command({cmd[7:5], 1'b1, 2'h2, 1'b1, cmd[0]});
    // Short frame is ignored
    send(8'h00, 5);
    chk({6'h00, card_reset_out_o, fast_edge_slope_o}, 8'h03);
    chk(hi_len, 8'h08);
    $display("test short_frame done");
    for (int f = 0; f < 4; f++) begin
      {battery_uv_i, battery_ov_i, card_supply_uv_i, card_supply_ov_i} <= 4'h1 << f;
      cyc(6);
      chk({4'h0, status_o}, 8'h01 << f);
      chk({7'h00, int_b_o}, {7'h00, f > 1});
      {battery_uv_i, battery_ov_i, card_supply_uv_i, card_supply_ov_i} <= 4'h0;
      cyc(6);
      command(8'h18);
      chk({3'h0, int_b_o, status_o}, 8'h10);
    end
    // A fault still present at the latch keeps its flag
    card_supply_uv_i <= 1'b1;
    command(8'h18);
    chk({3'h0, int_b_o, status_o}, 8'h02);
    $display("test supply_faults done");
    // Reset in mid-run while the card clock is low, then run again
    while (card_clock_out_o) cyc(1);
    rst_b_i <= 1'b0;
    cyc(5);
    chk({3'h0, card_clock_out_o, card_reset_out_o, fast_edge_slope_o, int_b_o, 1'b0}, 8'h02);
    chk({4'h0, status_o}, 8'h00);
    card_supply_uv_i <= 1'b0;
    cyc(1);
    rst_b_i <= 1'b1;
    cyc(2);
    command(8'h1c);
    chk({3'h0, int_b_o, status_o}, 8'h10);
    $display("test mid_reset done");
    chk({7'h00, too_fast}, 8'h00);
    complete_run();
  end
endmodule // ccd_card_clock_divider_test
